// *** rtl/pif_periph_irq.sv ***
// Peripheral interrupt enable and flag bank with AXI4-Lite access
`include "pif_consts.svh"
module pif_periph_irq (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PIF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`PIF_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic adcDoneEvent,
  input wire logic serialRxHasData,
  input wire logic serialTxBufEmpty,
  input wire logic syncSerialDoneEvent,
  input wire logic capcmpCaptureEvent,
  input wire logic capcmpCompareEvent,
  input wire pif_pkg::pif_ccp_mode_type capcmpMode,
  input wire logic timerBMatchEvent,
  input wire logic timerAOvfEvent,
  input wire logic [3:0] periphFlag2,
  input wire logic periphGroupEnable,
  output logic periphIrqReq,
  output logic irq
);
  import pif_pkg::*;

  pif_reg_if regBus (); // Carrier to the bus slave

  pif_byte_type en1_reg; // First enable register
  pif_byte_type en2_reg; // Second enable register
  pif_byte_type flag1_reg; // First request flag register
  pif_byte_type flag1_next;
  pif_byte_type status_reg; // Sticky event status for the interrupt line
  pif_byte_type status_next;
  pif_byte_type mask_reg; // Interrupt line mask
  logic periphIrqReq_reg; // Registered peripheral request
  logic irq_reg; // Registered interrupt line

  wire selEn1W; // Write decodes
  wire selEn2W;
  wire selFlag1W;
  wire selStatusW;
  wire selMaskW;
  wire capcmpEvent; // Capture or compare event, by mode
  wire [7:0] swFlagSet; // Hardware set terms of sticky flags
  wire [7:0] swFlagKeep; // Sticky flags after any software write
  wire [7:0] levelFlags; // Read-only flags that mirror buffer state
  wire [7:0] flag2Word; // Flags of the second register, aligned with enables
  wire reqNext; // Peripheral request before the register

  pif_axil_slave u_slave (
    .clock(clock),
    .reset(reset),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .regs(regBus.bus)
  );

  // Address decode for writes
  assign selEn1W = regBus.wrEn && (regBus.wrAddr == `PIF_OFF_EN1);
  assign selEn2W = regBus.wrEn && (regBus.wrAddr == `PIF_OFF_EN2);
  assign selFlag1W = regBus.wrEn && (regBus.wrAddr == `PIF_OFF_FLAG1);
  assign selStatusW = regBus.wrEn && (regBus.wrAddr == `PIF_OFF_IRQ_STATUS);
  assign selMaskW = regBus.wrEn && (regBus.wrAddr == `PIF_OFF_IRQ_MASK);
  assign regBus.wrHit = (regBus.wrAddr == `PIF_OFF_EN1) || (regBus.wrAddr == `PIF_OFF_EN2) ||
                        (regBus.wrAddr == `PIF_OFF_FLAG1) ||
                        (regBus.wrAddr == `PIF_OFF_IRQ_STATUS) ||
                        (regBus.wrAddr == `PIF_OFF_IRQ_MASK);

  // Read selection; unimplemented bits are masked to zero at the source
  assign regBus.rdHit = (regBus.rdAddr == `PIF_OFF_EN1) || (regBus.rdAddr == `PIF_OFF_EN2) ||
                        (regBus.rdAddr == `PIF_OFF_FLAG1) ||
                        (regBus.rdAddr == `PIF_OFF_IRQ_STATUS) ||
                        (regBus.rdAddr == `PIF_OFF_IRQ_MASK);
  assign regBus.rdData = (regBus.rdAddr == `PIF_OFF_EN1) ? en1_reg :
                         (regBus.rdAddr == `PIF_OFF_EN2) ? en2_reg :
                         (regBus.rdAddr == `PIF_OFF_FLAG1) ? flag1_reg :
                         (regBus.rdAddr == `PIF_OFF_IRQ_STATUS) ? status_reg :
                         (regBus.rdAddr == `PIF_OFF_IRQ_MASK) ? mask_reg : 8'h00;

  // Capture events count only in capture mode, compare only in compare mode
  assign capcmpEvent = ((capcmpMode == PIF_CCP_CAPTURE) && capcmpCaptureEvent) ||
                       ((capcmpMode == PIF_CCP_COMPARE) && capcmpCompareEvent);

  // Event set terms, independent of every enable
  assign swFlagSet = {1'b0, adcDoneEvent, 2'b00, syncSerialDoneEvent,
                      capcmpEvent, timerBMatchEvent, timerAOvfEvent};

  // A software write replaces the sticky bits; the set term below wins over a clear
  assign swFlagKeep = (selFlag1W ? regBus.wrData : flag1_reg) & `PIF_FLAG1_SW_MASK;

  // Buffer state flags are read-only and follow their sources
  assign levelFlags = {2'b00, serialRxHasData, serialTxBufEmpty, 4'h0};

  // Sticky set wins over software clear; bit 7 never stored
  assign flag1_next = ((swFlagKeep | swFlagSet) & `PIF_FLAG1_SW_MASK) | levelFlags;

  // Outside second flag register lines up with the second enable register
  assign flag2Word = {periphFlag2, 4'h0};

  // Request: any flag with its enable, then the group gate
  assign reqNext = periphGroupEnable &&
                   (|(flag1_reg & en1_reg) || |(flag2Word & en2_reg));

  // Status bits rise with any rising flag of the first flag register; write one clears, set wins
  assign status_next = (status_reg & ~(selStatusW ? regBus.wrData : 8'h00)) |
                       (flag1_next & ~flag1_reg);

  // Enable registers; unimplemented bits forced to zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      en1_reg <= `PIF_RESET_VALUE;
      en2_reg <= `PIF_RESET_VALUE;
    end else begin
      if (selEn1W) begin
        en1_reg <= regBus.wrData & `PIF_EN1_MASK;
      end
      if (selEn2W) begin
        en2_reg <= regBus.wrData & `PIF_EN2_MASK;
      end
    end
  end

  // Flag register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flag1_reg <= `PIF_RESET_VALUE;
    end else begin
      flag1_reg <= flag1_next;
    end
  end

  // Interrupt status, mask and registered outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_reg <= `PIF_RESET_VALUE;
      mask_reg <= `PIF_RESET_VALUE;
      periphIrqReq_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (selMaskW) begin
        mask_reg <= regBus.wrData;
      end
      periphIrqReq_reg <= reqNext;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign periphIrqReq = periphIrqReq_reg;
  assign irq = irq_reg;

  // Checks on the bank
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_group_gate;
    !periphGroupEnable |=> !periphIrqReq;
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("request without group enable");

  property p_flag_sets;
    (adcDoneEvent || timerAOvfEvent) |=> (flag1_reg[6] || !$past(adcDoneEvent)) &&
                                         (flag1_reg[0] || !$past(timerAOvfEvent));
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("event did not set its flag");

  property p_req_tracks;
    periphGroupEnable && (|(flag1_reg & en1_reg)) |=> periphIrqReq;
  endproperty
  a_req_tracks: assert property (p_req_tracks) else $error("enabled flag gave no request");

  property p_bit7_zero;
    !en1_reg[7] && !flag1_reg[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("bit 7 not zero");

  property p_en2_low;
    en2_reg[3:0] == 4'h0;
  endproperty
  a_en2_low: assert property (p_en2_low) else $error("enable2 low nibble set");

  property p_rx_tx_follow;
    ##1 (flag1_reg[5] == $past(serialRxHasData)) && (flag1_reg[4] == $past(serialTxBufEmpty));
  endproperty
  a_rx_tx_follow: assert property (p_rx_tx_follow) else $error("buffer flag mismatch");

  property p_adc_sticky;
    flag1_reg[6] && !(selFlag1W && !regBus.wrData[6]) |=> flag1_reg[6];
  endproperty
  a_adc_sticky: assert property (p_adc_sticky) else $error("adc flag lost");

  property p_ccp_pwm;
    !flag1_reg[2] && (capcmpMode == PIF_CCP_PWM) && !selFlag1W |=> !flag1_reg[2];
  endproperty
  a_ccp_pwm: assert property (p_ccp_pwm) else $error("capcmp flag set in pwm");

  property p_sticky_rest;
    (flag1_reg & 8'h0B) != 8'h00 && !selFlag1W |=> (flag1_reg & $past(flag1_reg) & 8'h0B) ==
                                                    ($past(flag1_reg) & 8'h0B);
  endproperty
  a_sticky_rest: assert property (p_sticky_rest) else $error("sticky flag dropped");

  property p_irq_line;
    (|(status_reg & mask_reg)) && !selStatusW && !selMaskW |=> irq;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq line low with pending status");

  // Each sticky source sets its own flag on the edge after its strobe
  property p_adc_sets;
    adcDoneEvent |=> flag1_reg[6];
  endproperty
  a_adc_sets: assert property (p_adc_sets) else $error("adc flag not set");

  // Sync serial completion is sticky like the conversion flag
  property p_ssp_sets;
    syncSerialDoneEvent |=> flag1_reg[3];
  endproperty
  a_ssp_sets: assert property (p_ssp_sets) else $error("sync serial flag not set");

  // Timer B period match
  property p_tmrb_sets;
    timerBMatchEvent |=> flag1_reg[1];
  endproperty
  a_tmrb_sets: assert property (p_tmrb_sets) else $error("timer b flag not set");

  // Timer A overflow
  property p_tmra_sets;
    timerAOvfEvent |=> flag1_reg[0];
  endproperty
  a_tmra_sets: assert property (p_tmra_sets) else $error("timer a flag not set");

  // A capture strobe counts only while the unit is in capture mode
  property p_cap_sets;
    capcmpCaptureEvent && (capcmpMode == PIF_CCP_CAPTURE) |=> flag1_reg[2];
  endproperty
  a_cap_sets: assert property (p_cap_sets) else $error("capture did not set flag");

  // A compare strobe counts only while the unit is in compare mode
  property p_cmp_sets;
    capcmpCompareEvent && (capcmpMode == PIF_CCP_COMPARE) |=> flag1_reg[2];
  endproperty
  a_cmp_sets: assert property (p_cmp_sets) else $error("compare did not set flag");

  // Transmit flag follows buffer state with one cycle of latency
  property p_tx_follow;
    ##1 flag1_reg[4] == $past(serialTxBufEmpty);
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("transmit flag mismatch");

  // No enabled flag in either bank means no request on the next cycle
  property p_req_off;
    !(|(flag1_reg & en1_reg)) && !(|(flag2Word & en2_reg)) |=> !periphIrqReq;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request without enabled flag");

  // Enable writes keep only the implemented bits
  property p_en1_write;
    selEn1W |=> en1_reg == ($past(regBus.wrData) & `PIF_EN1_MASK);
  endproperty
  a_en1_write: assert property (p_en1_write) else $error("enable1 write wrong");

  property p_en2_write;
    selEn2W |=> en2_reg == ($past(regBus.wrData) & `PIF_EN2_MASK);
  endproperty
  a_en2_write: assert property (p_en2_write) else $error("enable2 write wrong");

  // A rising flag always lands in the status register
  property p_status_set;
    (flag1_next & ~flag1_reg) != 8'h00 |=>
      (status_reg & $past(flag1_next & ~flag1_reg)) == $past(flag1_next & ~flag1_reg);
  endproperty
  a_status_set: assert property (p_status_set) else $error("status bit not set");

  // Nothing pending and unmasked keeps the line low
  property p_irq_low;
    !(|(status_next & mask_reg)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq line high without cause");

  // Unmapped writes are answered with an error code
  property p_wr_slverr;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && !regBus.wrHit |=>
      s_axi_bvalid && (s_axi_bresp == `PIF_RESP_SLVERR);
  endproperty
  a_wr_slverr: assert property (p_wr_slverr) else $error("unmapped write not refused");

  c_adc_req: cover property (adcDoneEvent && en1_reg[6] && periphGroupEnable ##2 periphIrqReq);
  c_cmp_flag: cover property (capcmpCompareEvent && (capcmpMode == PIF_CCP_COMPARE) ##1 flag1_reg[2]);
  c_flag2_req: cover property (|(flag2Word & en2_reg) && periphGroupEnable ##1 periphIrqReq);
  c_flag_clear: cover property (flag1_reg[0] && selFlag1W && !regBus.wrData[0] ##1 !flag1_reg[0]);
  c_status_clear: cover property (irq ##1 selStatusW ##2 !irq);
endmodule // pif_periph_irq

// *** rtl/pif_consts.svh ***
// Offsets, field positions and reset values of the peripheral interrupt bank
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH
`define PIF_ADDR_W 8
`define PIF_OFF_EN1 8'h00
`define PIF_OFF_EN2 8'h04
`define PIF_OFF_FLAG1 8'h08
`define PIF_OFF_IRQ_STATUS 8'h0C
`define PIF_OFF_IRQ_MASK 8'h10
`define PIF_EN1_MASK 8'h7F
`define PIF_EN2_MASK 8'hF0
`define PIF_FLAG1_MASK 8'h7F
`define PIF_FLAG1_SW_MASK 8'h4F
`define PIF_RESET_VALUE 8'h00
`define PIF_BIT_ADC 6
`define PIF_BIT_RX 5
`define PIF_BIT_TX 4
`define PIF_BIT_SSP 3
`define PIF_BIT_CCP 2
`define PIF_BIT_TMRB 1
`define PIF_BIT_TMRA 0
`define PIF_RESP_OKAY 2'h0
`define PIF_RESP_SLVERR 2'h2
`endif

// *** rtl/pif_pkg.sv ***
// Types shared by the peripheral interrupt bank
package pif_pkg;
  // Operating mode of the capture/compare unit
  typedef enum logic [1:0] {
    PIF_CCP_CAPTURE,
    PIF_CCP_COMPARE,
    PIF_CCP_PWM,
    PIF_CCP_OFF
  } pif_ccp_mode_type;
  // Register byte
  typedef logic [7:0] pif_byte_type;
endpackage

// *** rtl/pif_reg_if.sv ***
// Register access carrier between the bus slave and the register bank
interface pif_reg_if;
  logic wrEn; // One-cycle write strobe, low byte enabled
  logic [7:0] wrAddr; // Write byte address
  logic [7:0] wrData; // Write low byte
  logic [7:0] rdAddr; // Read byte address, valid at read handshake
  logic [7:0] rdData; // Read data for rdAddr
  logic rdHit; // rdAddr is mapped
  logic wrHit; // wrAddr is mapped
  modport bus (output wrEn, output wrAddr, output wrData, output rdAddr,
               input rdData, input rdHit, input wrHit);
  modport regs (input wrEn, input wrAddr, input wrData, input rdAddr,
                output rdData, output rdHit, output wrHit);
endinterface

// *** rtl/pif_axil_slave.sv ***
// AXI4-Lite slave front end for the peripheral interrupt bank
`include "pif_consts.svh"
module pif_axil_slave (
  input wire logic clock,
  input wire logic reset,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`PIF_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`PIF_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  pif_reg_if.bus regs
);
  import pif_pkg::*;
  logic bvalid_reg; // Write response pending
  logic [1:0] bresp_reg; // Write response code
  logic rvalid_reg; // Read response pending
  logic [31:0] rdata_reg; // Read data held for the master
  logic [1:0] rresp_reg; // Read response code
  wire wrTake; // Address and data taken together
  wire rdTake; // Read address taken

  // Both write channels wait for each other, so arrival order does not matter
  assign wrTake = awvalid && wvalid && !bvalid_reg;
  assign awready = wrTake;
  assign wready = wrTake;
  assign arready = !rvalid_reg;
  assign rdTake = arvalid && !rvalid_reg;
  assign regs.wrEn = wrTake && wstrb[0];
  assign regs.wrAddr = awaddr;
  assign regs.wrData = wdata[7:0];
  assign regs.rdAddr = araddr;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Write response one cycle after the handshake
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PIF_RESP_OKAY;
    end else if (wrTake) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= regs.wrHit ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data captured at the handshake; unmapped reads give zero and SLVERR
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `PIF_RESP_OKAY;
    end else if (rdTake) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, regs.rdData};
      rresp_reg <= regs.rdHit ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule // pif_axil_slave

// *** dv/pif_event_source.sv ***
// Behavioural model of the peripheral event sources and core enable lines
module pif_event_source (
  input wire logic clock,
  output logic adcEv,
  output logic sspEv,
  output logic capEv,
  output logic cmpEv,
  output logic tmrBEv,
  output logic tmrAEv,
  output logic rxLvl,
  output logic txLvl,
  output logic [3:0] flag2,
  output logic grp,
  output pif_pkg::pif_ccp_mode_type mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import pif_pkg::*;
  // Everything quiet until a scenario asks
  initial begin
    {adcEv, sspEv, capEv, cmpEv, tmrBEv, tmrAEv, rxLvl, txLvl, grp} = 9'h000;
    flag2 = 4'h0;
    mode = PIF_CCP_OFF;
  end
  // One-cycle strobe; sources never hold an event longer than one edge
  task automatic pulse(input int which);
    @(posedge clock);
    {adcEv, sspEv, capEv, cmpEv, tmrBEv, tmrAEv} <= 6'h20 >> which;
    @(posedge clock);
    {adcEv, sspEv, capEv, cmpEv, tmrBEv, tmrAEv} <= 6'h00;
  endtask
  // Level lines: buffer state, second flag bank, group enable, unit mode
  task automatic setLines(input logic rx, input logic tx, input logic [3:0] f2,
                          input logic g, input pif_ccp_mode_type m);
    @(posedge clock);
    rxLvl <= rx;
    txLvl <= tx;
    flag2 <= f2;
    grp <= g;
    mode <= m;
  endtask
endmodule // pif_event_source

// *** dv/pif_periph_irq_tb_top.sv ***
// Self-checking bench for the peripheral interrupt bank
`include "pif_consts.svh"
module pif_periph_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pif_pkg::*;
  logic clock, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, periphIrqReq, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, flag2;
  logic [1:0] bresp, rresp;
  logic adcEv, sspEv, capEv, cmpEv, tmrBEv, tmrAEv, rxLvl, txLvl, grp;
  pif_ccp_mode_type mode;
  int errTotal = 0;
  int checked = 0;
  int cycles = 0;
  // 125 MHz core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  pif_periph_irq u_dut (.clock(clock), .reset(reset), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .adcDoneEvent(adcEv), .serialRxHasData(rxLvl),
    .serialTxBufEmpty(txLvl), .syncSerialDoneEvent(sspEv), .capcmpCaptureEvent(capEv),
    .capcmpCompareEvent(cmpEv), .capcmpMode(mode), .timerBMatchEvent(tmrBEv),
    .timerAOvfEvent(tmrAEv), .periphFlag2(flag2), .periphGroupEnable(grp),
    .periphIrqReq(periphIrqReq), .irq(irq));
  pif_event_source u_src (.clock(clock), .adcEv(adcEv), .sspEv(sspEv), .capEv(capEv),
    .cmpEv(cmpEv), .tmrBEv(tmrBEv), .tmrAEv(tmrAEv), .rxLvl(rxLvl), .txLvl(txLvl),
    .flag2(flag2), .grp(grp), .mode(mode));
  // Verdict and end of run, shared by the main flow and the watchdog
  task automatic final_report();
    if (errTotal == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h000000, d};
    bready <= 1'b1;
    do @(posedge clock); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clock);
    bready <= 1'b0;
    chk($sformatf("bresp@%h", a), er, bresp);
  endtask
  // Bus read; upper data bits must come back zero
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    rready <= 1'b0;
    chk($sformatf("rdata@%h", a), {24'h000000, e}, rdata);
    chk($sformatf("rresp@%h", a), er, rresp);
  endtask
  task automatic t_reset();
    logic [7:0] offs [5] = '{`PIF_OFF_EN1, `PIF_OFF_EN2, `PIF_OFF_FLAG1,
                             `PIF_OFF_IRQ_STATUS, `PIF_OFF_IRQ_MASK};
    for (int i = 0; i < 5; i++) rd(offs[i], `PIF_RESET_VALUE, `PIF_RESP_OKAY);
    chk("periphIrqReq", 1'b0, periphIrqReq);
  endtask
  // Unimplemented bits, read-only flag bits and an unmapped word
  task automatic t_access();
    wr(`PIF_OFF_EN1, 8'hFF, `PIF_RESP_OKAY);
    rd(`PIF_OFF_EN1, 8'h7F, `PIF_RESP_OKAY);
    wr(`PIF_OFF_EN2, 8'hFF, `PIF_RESP_OKAY);
    rd(`PIF_OFF_EN2, 8'hF0, `PIF_RESP_OKAY);
    wr(`PIF_OFF_FLAG1, 8'hFF, `PIF_RESP_OKAY);
    rd(`PIF_OFF_FLAG1, 8'h4F, `PIF_RESP_OKAY);
    wr(8'h14, 8'h5A, `PIF_RESP_SLVERR);
    rd(8'h14, 8'h00, `PIF_RESP_SLVERR);
    wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
    rd(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
    wr(`PIF_OFF_EN1, 8'h00, `PIF_RESP_OKAY);
    wr(`PIF_OFF_EN2, 8'h00, `PIF_RESP_OKAY);
    wr(`PIF_OFF_IRQ_STATUS, 8'hFF, `PIF_RESP_OKAY);
  endtask
  // Sticky sources with every enable off: flag rises, request stays low
  task automatic t_sticky();
    int ev [4] = '{0, 1, 4, 5};
    int pos [4] = '{6, 3, 1, 0};
    for (int i = 0; i < 4; i++) begin
      u_src.pulse(ev[i]);
      repeat (6) @(posedge clock);
      rd(`PIF_OFF_FLAG1, 8'h01 << pos[i], `PIF_RESP_OKAY);
      chk("periphIrqReq", 1'b0, periphIrqReq);
      wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
    end
  endtask
  // Capture and compare strobes counted only in their own mode
  task automatic t_capcmp();
    for (int m = 0; m < 4; m++) begin
      u_src.setLines(1'b0, 1'b0, 4'h0, 1'b0, pif_ccp_mode_type'(m));
      u_src.pulse(2);
      rd(`PIF_OFF_FLAG1, (m == 0) ? 8'h04 : 8'h00, `PIF_RESP_OKAY);
      wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
      u_src.pulse(3);
      rd(`PIF_OFF_FLAG1, (m == 1) ? 8'h04 : 8'h00, `PIF_RESP_OKAY);
      wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
    end
  endtask
  // Buffer-state flags follow the serial unit, software cannot clear them
  task automatic t_levels();
    u_src.setLines(1'b1, 1'b0, 4'h0, 1'b0, PIF_CCP_OFF);
    rd(`PIF_OFF_FLAG1, 8'h20, `PIF_RESP_OKAY);
    u_src.setLines(1'b1, 1'b1, 4'h0, 1'b0, PIF_CCP_OFF);
    wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
    rd(`PIF_OFF_FLAG1, 8'h30, `PIF_RESP_OKAY);
    u_src.setLines(1'b0, 1'b0, 4'h0, 1'b0, PIF_CCP_OFF);
    rd(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
  endtask
  // Request needs flag, its enable and the group enable together
  task automatic t_request();
    wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
    wr(`PIF_OFF_EN1, 8'h40, `PIF_RESP_OKAY);
    u_src.pulse(0);
    repeat (3) @(posedge clock);
    chk("periphIrqReq", 1'b0, periphIrqReq);
    u_src.setLines(1'b0, 1'b0, 4'h0, 1'b1, PIF_CCP_OFF);
    repeat (3) @(posedge clock);
    chk("periphIrqReq", 1'b1, periphIrqReq);
    wr(`PIF_OFF_EN1, 8'h00, `PIF_RESP_OKAY);
    repeat (3) @(posedge clock);
    chk("periphIrqReq", 1'b0, periphIrqReq);
    wr(`PIF_OFF_EN2, 8'h80, `PIF_RESP_OKAY);
    u_src.setLines(1'b0, 1'b0, 4'h8, 1'b1, PIF_CCP_OFF);
    repeat (3) @(posedge clock);
    chk("periphIrqReq", 1'b1, periphIrqReq);
    u_src.setLines(1'b0, 1'b0, 4'h7, 1'b1, PIF_CCP_OFF);
    repeat (3) @(posedge clock);
    chk("periphIrqReq", 1'b0, periphIrqReq);
    u_src.setLines(1'b0, 1'b0, 4'h0, 1'b0, PIF_CCP_OFF);
    wr(`PIF_OFF_EN2, 8'h00, `PIF_RESP_OKAY);
    wr(`PIF_OFF_FLAG1, 8'h00, `PIF_RESP_OKAY);
  endtask
  // Status raised by an event, masked, unmasked and cleared by writing one
  task automatic t_irq();
    wr(`PIF_OFF_IRQ_STATUS, 8'hFF, `PIF_RESP_OKAY);
    wr(`PIF_OFF_IRQ_MASK, 8'h40, `PIF_RESP_OKAY);
    u_src.pulse(0);
    repeat (3) @(posedge clock);
    chk("irq", 1'b1, irq);
    rd(`PIF_OFF_IRQ_STATUS, 8'h40, `PIF_RESP_OKAY);
    wr(`PIF_OFF_IRQ_MASK, 8'h00, `PIF_RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("irq", 1'b0, irq);
    wr(`PIF_OFF_IRQ_MASK, 8'h40, `PIF_RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("irq", 1'b1, irq);
    wr(`PIF_OFF_IRQ_STATUS, 8'h40, `PIF_RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("irq", 1'b0, irq);
    rd(`PIF_OFF_IRQ_STATUS, 8'h00, `PIF_RESP_OKAY);
  endtask
  // Watchdog: the whole flow needs well under a thousand cycles
  initial begin
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles == 5000) begin
        errTotal++;
        final_report();
      end
    end
  end
  // Main flow: eight cycles of reset, then each scenario in turn
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_access();
    t_sticky();
    t_capcmp();
    t_levels();
    t_request();
    t_irq();
    final_report();
  end
endmodule // pif_periph_irq_tb_top
